/* File: hdl/tap_scan_pkg.sv */
/*
 * Shared constants and types for the test access port scan block:
 * controller states, instruction codes, register widths, reset values
 * and the word carried from the test-clock domain to the system domain.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package tap_scan_pkg;

    // ****************************************************************
    // Register widths and fixed values.
    // ****************************************************************

    // Width of the instruction register.
    localparam int IR_WIDTH = 8;
    // Width of the general data register selected by non-bypass codes.
    localparam int DR_WIDTH = 8;
    // Pattern loaded into the instruction shift register on capture.
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 8'h81;
    // All-ones instruction that selects the bypass register.
    localparam logic [IR_WIDTH-1:0] IR_BYPASS = 8'hFF;
    // Active instruction after reset and in test-logic-reset.
    localparam logic [IR_WIDTH-1:0] IR_RESET = 8'hFF;
    // Reset value of the instruction shift register.
    localparam logic [IR_WIDTH-1:0] IR_SHIFT_RESET = 8'h00;
    // Value the bypass stage loads on data capture.
    localparam logic BYPASS_CAPTURE = 1'h0;
    // Reset value of the data shift register and its parallel latch.
    localparam logic [DR_WIDTH-1:0] DR_RESET = 8'h00;

    // ****************************************************************
    // Types.
    // ****************************************************************

    // The sixteen controller states.
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR_SCAN,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR_SCAN,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

    // Parallel results carried across to the system clock.
    typedef struct packed {
        logic [IR_WIDTH-1:0] instr;
        logic [DR_WIDTH-1:0] data;
        logic bypass_sel;
    } scan_word_t;

    // Value of the carried word after reset.
    localparam scan_word_t WORD_RESET = '{instr: IR_RESET, data: DR_RESET, bypass_sel: 1'h1};

endpackage

/* File: hdl/tap_ir_bypass_scan.sv */
/*
 * Test access port scan logic: sixteen-state controller, 8-bit
 * instruction register, single-stage bypass register, a general data
 * register, serial output with enable, and a handshake that hands the
 * active instruction and data latch over to the system clock domain.
 * Assumes the external test controller drives tck_in, tms_in and
 * tdi_in, changing tms_in and tdi_in on falling test-clock edges, and
 * that rst_n_in and clk_en_in belong to sys_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module tap_ir_bypass_scan (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    output logic [tap_scan_pkg::IR_WIDTH-1:0] instr_out,
    output logic [tap_scan_pkg::DR_WIDTH-1:0] dr_par_out,
    output logic bypass_sel_out
);

    // ****************************************************************
    // Test-clock domain: reset and enable synchronisers.
    // ****************************************************************

    logic rst_meta;
    logic rst_sync;
    logic en_meta;
    logic en_sync;
    logic ack_meta;
    logic ack_sync;
    logic tck_rst;
    // Acknowledge toggle, driven by the system-side receive logic below.
    logic ack_tgl;

    // Reset, enable and returning acknowledge cross on two flip-flops.
    always_ff @(posedge tck_in) begin
        rst_meta <= rst_n_in;
        rst_sync <= rst_meta;
        en_meta <= clk_en_in;
        en_sync <= en_meta;
        ack_meta <= ack_tgl;
        ack_sync <= ack_meta;
    end

    // The test logic is held in reset while the system reset stands; it
    // enters and leaves reset two test-clock edges after the system side.
    assign tck_rst = !rst_sync;

    // ****************************************************************
    // Test-clock domain: controller state.
    // ****************************************************************

    tap_scan_pkg::tap_state_t state;
    tap_scan_pkg::tap_state_t next_state;

    // Next controller state from mode select sampled on the rising edge.
    always_comb begin
        next_state = state;
        unique case (state)
            tap_scan_pkg::TEST_LOGIC_RESET: begin
                next_state = tms_in ? tap_scan_pkg::TEST_LOGIC_RESET
                                    : tap_scan_pkg::RUN_TEST_IDLE;
            end
            tap_scan_pkg::RUN_TEST_IDLE: begin
                next_state = tms_in ? tap_scan_pkg::SELECT_DR_SCAN
                                    : tap_scan_pkg::RUN_TEST_IDLE;
            end
            tap_scan_pkg::SELECT_DR_SCAN: begin
                next_state = tms_in ? tap_scan_pkg::SELECT_IR_SCAN
                                    : tap_scan_pkg::CAPTURE_DR;
            end
            tap_scan_pkg::CAPTURE_DR: begin
                next_state = tms_in ? tap_scan_pkg::EXIT1_DR
                                    : tap_scan_pkg::SHIFT_DR;
            end
            tap_scan_pkg::SHIFT_DR: begin
                next_state = tms_in ? tap_scan_pkg::EXIT1_DR
                                    : tap_scan_pkg::SHIFT_DR;
            end
            tap_scan_pkg::EXIT1_DR: begin
                next_state = tms_in ? tap_scan_pkg::UPDATE_DR
                                    : tap_scan_pkg::PAUSE_DR;
            end
            tap_scan_pkg::PAUSE_DR: begin
                next_state = tms_in ? tap_scan_pkg::EXIT2_DR
                                    : tap_scan_pkg::PAUSE_DR;
            end
            tap_scan_pkg::EXIT2_DR: begin
                next_state = tms_in ? tap_scan_pkg::UPDATE_DR
                                    : tap_scan_pkg::SHIFT_DR;
            end
            tap_scan_pkg::UPDATE_DR: begin
                next_state = tms_in ? tap_scan_pkg::SELECT_DR_SCAN
                                    : tap_scan_pkg::RUN_TEST_IDLE;
            end
            tap_scan_pkg::SELECT_IR_SCAN: begin
                next_state = tms_in ? tap_scan_pkg::TEST_LOGIC_RESET
                                    : tap_scan_pkg::CAPTURE_IR;
            end
            tap_scan_pkg::CAPTURE_IR: begin
                next_state = tms_in ? tap_scan_pkg::EXIT1_IR
                                    : tap_scan_pkg::SHIFT_IR;
            end
            tap_scan_pkg::SHIFT_IR: begin
                next_state = tms_in ? tap_scan_pkg::EXIT1_IR
                                    : tap_scan_pkg::SHIFT_IR;
            end
            tap_scan_pkg::EXIT1_IR: begin
                next_state = tms_in ? tap_scan_pkg::UPDATE_IR
                                    : tap_scan_pkg::PAUSE_IR;
            end
            tap_scan_pkg::PAUSE_IR: begin
                next_state = tms_in ? tap_scan_pkg::EXIT2_IR
                                    : tap_scan_pkg::PAUSE_IR;
            end
            tap_scan_pkg::EXIT2_IR: begin
                next_state = tms_in ? tap_scan_pkg::UPDATE_IR
                                    : tap_scan_pkg::SHIFT_IR;
            end
            tap_scan_pkg::UPDATE_IR: begin
                next_state = tms_in ? tap_scan_pkg::SELECT_DR_SCAN
                                    : tap_scan_pkg::RUN_TEST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Test-clock domain: shift registers on the rising edge.
    // ****************************************************************

    logic [tap_scan_pkg::IR_WIDTH-1:0] ir_shift;
    logic [tap_scan_pkg::IR_WIDTH-1:0] next_ir_shift;
    logic bypass_bit;
    logic next_bypass_bit;
    logic [tap_scan_pkg::DR_WIDTH-1:0] dr_shift;
    logic [tap_scan_pkg::DR_WIDTH-1:0] next_dr_shift;
    logic [tap_scan_pkg::IR_WIDTH-1:0] ir_active;
    logic [tap_scan_pkg::DR_WIDTH-1:0] dr_latch;
    logic bypass_sel;

    // The bypass stage is chosen only by the all-ones instruction.
    assign bypass_sel = (ir_active == tap_scan_pkg::IR_BYPASS);

    // Instruction and bypass capture load fixed values, data capture loads the latch; shift moves one bit in, least bit out.
    always_comb begin
        next_ir_shift = ir_shift;
        next_bypass_bit = bypass_bit;
        next_dr_shift = dr_shift;
        if (state == tap_scan_pkg::CAPTURE_IR) begin
            next_ir_shift = tap_scan_pkg::IR_CAPTURE;
        end
        if (state == tap_scan_pkg::SHIFT_IR) begin
            // Shifts on every edge in the state, the exit edge included.
            next_ir_shift = {tdi_in, ir_shift[tap_scan_pkg::IR_WIDTH-1:1]};
        end
        if (state == tap_scan_pkg::CAPTURE_DR) begin
            if (bypass_sel) begin
                next_bypass_bit = tap_scan_pkg::BYPASS_CAPTURE;
            end else begin
                next_dr_shift = dr_latch;
            end
        end
        if (state == tap_scan_pkg::SHIFT_DR) begin
            if (bypass_sel) begin
                next_bypass_bit = tdi_in;
            end else begin
                next_dr_shift = {tdi_in, dr_shift[tap_scan_pkg::DR_WIDTH-1:1]};
            end
        end
    end

    // Rising-edge registers; the enable freezes them while low.
    always_ff @(posedge tck_in) begin
        if (tck_rst) begin
            state <= tap_scan_pkg::TEST_LOGIC_RESET;
            ir_shift <= tap_scan_pkg::IR_SHIFT_RESET;
            bypass_bit <= tap_scan_pkg::BYPASS_CAPTURE;
            dr_shift <= tap_scan_pkg::DR_RESET;
        end else if (en_sync) begin
            state <= next_state;
            ir_shift <= next_ir_shift;
            bypass_bit <= next_bypass_bit;
            dr_shift <= next_dr_shift;
        end
    end

    // ****************************************************************
    // Test-clock domain: output and update latches on the falling edge.
    // ****************************************************************

    logic next_tdo;
    logic next_tdo_oe;
    logic [tap_scan_pkg::IR_WIDTH-1:0] next_ir_active;
    logic [tap_scan_pkg::DR_WIDTH-1:0] next_dr_latch;

    // Serial output drives only in the shift states; updates latch here.
    always_comb begin
        next_tdo_oe = (state == tap_scan_pkg::SHIFT_IR)
                   || (state == tap_scan_pkg::SHIFT_DR);
        if (state == tap_scan_pkg::SHIFT_IR) begin
            next_tdo = ir_shift[0];
        end else if (bypass_sel) begin
            next_tdo = bypass_bit;
        end else begin
            next_tdo = dr_shift[0];
        end
        next_ir_active = ir_active;
        next_dr_latch = dr_latch;
        if (state == tap_scan_pkg::TEST_LOGIC_RESET) begin
            next_ir_active = tap_scan_pkg::IR_RESET;
        end
        if (state == tap_scan_pkg::UPDATE_IR) begin
            next_ir_active = ir_shift;
        end
        if ((state == tap_scan_pkg::UPDATE_DR) && !bypass_sel) begin
            next_dr_latch = dr_shift;
        end
    end

    // Falling-edge registers, so the output changes only on that edge.
    always_ff @(negedge tck_in) begin
        if (tck_rst) begin
            tdo_out <= 1'h0;
            tdo_oe_out <= 1'h0;
            ir_active <= tap_scan_pkg::IR_RESET;
            dr_latch <= tap_scan_pkg::DR_RESET;
        end else if (en_sync) begin
            tdo_out <= next_tdo;
            tdo_oe_out <= next_tdo_oe;
            ir_active <= next_ir_active;
            dr_latch <= next_dr_latch;
        end
    end

    // ****************************************************************
    // Hand-over to the system clock: toggle request and acknowledge.
    // ****************************************************************

    tap_scan_pkg::scan_word_t cur_word;
    tap_scan_pkg::scan_word_t xfer_word;
    tap_scan_pkg::scan_word_t next_xfer_word;
    logic req_tgl;
    logic next_req_tgl;

    // Gathers the latched results into the word that crosses domains.
    assign cur_word = '{instr: ir_active, data: dr_latch, bypass_sel: bypass_sel};

    // A new word is sent only when the previous one was acknowledged,
    // so the held word never changes while the other side samples it.
    // Changes made while a word is in flight are merged; the latest one
    // goes out once the acknowledge is back, which needs the test clock.
    always_comb begin
        next_xfer_word = xfer_word;
        next_req_tgl = req_tgl;
        if ((req_tgl == ack_sync) && (cur_word != xfer_word)) begin
            next_xfer_word = cur_word;
            next_req_tgl = !req_tgl;
        end
    end

    // Request side registers, on the rising test-clock edge.
    always_ff @(posedge tck_in) begin
        if (tck_rst) begin
            xfer_word <= tap_scan_pkg::WORD_RESET;
            req_tgl <= 1'h0;
        end else if (en_sync) begin
            xfer_word <= next_xfer_word;
            req_tgl <= next_req_tgl;
        end
    end

    // ****************************************************************
    // System clock domain: receive side.
    // ****************************************************************

    logic req_meta;
    logic req_sync;
    logic next_ack_tgl;
    logic [tap_scan_pkg::IR_WIDTH-1:0] next_instr;
    logic [tap_scan_pkg::DR_WIDTH-1:0] next_dr_par;
    logic next_bypass_sel;

    // Request toggle crosses on two flip-flops.
    always_ff @(posedge sys_clk_in) begin
        req_meta <= req_tgl;
        req_sync <= req_meta;
    end

    // A changed request takes the held word and acknowledges it.
    always_comb begin
        next_ack_tgl = ack_tgl;
        next_instr = instr_out;
        next_dr_par = dr_par_out;
        next_bypass_sel = bypass_sel_out;
        if (req_sync != ack_tgl) begin
            next_ack_tgl = req_sync;
            next_instr = xfer_word.instr;
            next_dr_par = xfer_word.data;
            next_bypass_sel = xfer_word.bypass_sel;
        end
    end

    // System-side registers with synchronous reset and enable.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ack_tgl <= 1'h0;
            instr_out <= tap_scan_pkg::IR_RESET;
            dr_par_out <= tap_scan_pkg::DR_RESET;
            bypass_sel_out <= 1'h1;
        end else if (clk_en_in) begin
            ack_tgl <= next_ack_tgl;
            instr_out <= next_instr;
            dr_par_out <= next_dr_par;
            bypass_sel_out <= next_bypass_sel;
        end
    end

endmodule

`default_nettype wire

/* File: verification/tap_scan_checker.sv */
/*
 * Concurrent checks on the scan block's ports, with a shadow controller.
 * Assumes it is bound to the top module and that tms and tdi change on falling test-clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module tap_scan_checker (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    input wire logic [tap_scan_pkg::IR_WIDTH-1:0] instr_out,
    input wire logic [tap_scan_pkg::DR_WIDTH-1:0] dr_par_out,
    input wire logic bypass_sel_out
);
    // ****************************************************************
    // Shadow controller.
    // ****************************************************************

    // Next-state tables, one nibble per state in the package's state order.
    localparam logic [63:0] NX0 = 64'h1BDDBBA146644311;
    localparam logic [63:0] NX1 = 64'h2FEFCC0287855920;
    localparam logic [3:0] TLR = 4'h0;
    localparam logic [3:0] CDR = 4'h3;
    localparam logic [3:0] SHDR = 4'h4;
    localparam logic [3:0] UDR = 4'h8;
    localparam logic [3:0] CIR = 4'hA;
    localparam logic [3:0] SHIR = 4'hB;
    localparam logic [3:0] UIR = 4'hF;
    logic [3:0] st;
    logic [3:0] next_st;
    logic [7:0] ish;
    logic [7:0] next_ish;
    logic [7:0] dsh;
    logic [7:0] next_dsh;

    // Follows the state graph and mirrors the bits shifted in, LSB first.
    always_comb begin
        next_st = rst_n_in ? (tms_in ? NX1[4*st+:4] : NX0[4*st+:4]) : TLR;
        next_ish = (st == SHIR) ? {tdi_in, ish[7:1]} : ish;
        next_dsh = (st == SHDR) ? {tdi_in, dsh[7:1]} : dsh;
    end

    // Registers the shadow state.
    always_ff @(posedge tck_in) begin
        st <= next_st;
        ish <= next_ish;
        dsh <= next_dsh;
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************

    a_oe_in_shift: assert property (@(posedge tck_in) disable iff (!rst_n_in)
        tdo_oe_out == (st == SHIR || st == SHDR)) else $error("serial enable outside shift");
    a_capture_first_bit: assert property (@(posedge tck_in) disable iff (!rst_n_in)
        st == SHIR && $past(st) == CIR |-> tdo_out) else $error("capture pattern bit0 wrong");
    a_capture_second_bit: assert property (@(posedge tck_in) disable iff (!rst_n_in)
        st == SHIR && $past(st) == SHIR && $past(st, 2) == CIR |-> !tdo_out)
        else $error("capture pattern bit1 wrong");
    a_bypass_zero: assert property (@(posedge tck_in) disable iff (!rst_n_in)
        st == SHDR && $past(st) == CDR && bypass_sel_out |-> !tdo_out) else $error("bypass not 0");
    a_bypass_delay: assert property (@(posedge tck_in) disable iff (!rst_n_in)
        st == SHDR && $past(st) == SHDR && bypass_sel_out |-> tdo_out == $past(tdi_in))
        else $error("bypass delay wrong");
    a_ir_update: assert property (@(posedge tck_in) disable iff (!rst_n_in)
        st == UIR |-> ##[1:40] instr_out == ish) else $error("instruction not updated");
    a_dr_update: assert property (@(posedge tck_in) disable iff (!rst_n_in)
        st == UDR && !bypass_sel_out |-> ##[1:40] dr_par_out == dsh)
        else $error("data latch wrong");
    a_tlr_bypass: assert property (@(posedge tck_in) disable iff (!rst_n_in)
        st == TLR && $past(st) != TLR |-> ##[1:40] instr_out == tap_scan_pkg::IR_RESET)
        else $error("reset state did not restore instruction");
    a_bypass_sel: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        bypass_sel_out == (instr_out == tap_scan_pkg::IR_BYPASS)) else $error("bypass select wrong");

    // Main scenarios reached.
    c_bypass_shift: cover property (@(posedge tck_in) st == SHDR && bypass_sel_out);
    c_dr_update: cover property (@(posedge tck_in) st == UDR && !bypass_sel_out);
    c_ir_update: cover property (@(posedge tck_in) st == UIR);
endmodule

`default_nettype wire

/* File: verification/scan_ctrl_model.sv */
/*
 * Behavioural boundary-scan test controller: makes the test clock and walks the controller.
 * Assumes the device drives tdo with an enable; a released line reads as the inverse of its last bit.
 */
`timescale 1ns/1ps
`default_nettype none

module scan_ctrl_model (
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in,
    input wire logic tdo_oe_in
);
    logic held;
    logic b;
    wire logic line = tdo_oe_in ? tdo_in : ~held;

    // Test clock at 15 ns; mode select starts high so the device sits in reset state.
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
        held = 1'b0;
        // An odd start offset keeps test-clock edges apart from system-clock edges.
        #3.3;
        forever #7.5 tck_out = ~tck_out;
    end

    // Remembers the last driven serial bit so a released line can be modelled.
    always @(posedge tck_out) begin
        if (tdo_oe_in) held <= tdo_in;
    end

    // One cycle: change on the falling edge, sample on the rising edge.
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge tck_out);
        tms_out = m;
        tdi_out = d;
        @(posedge tck_out);
        q = line;
    endtask

    // One cycle outside a shift, with test data toggling as junk.
    task automatic nav(input logic m);
        step(m, ~tdi_out, b);
    endtask

    // Five high mode-select cycles reach the reset state from anywhere.
    task automatic to_tlr();
        repeat (5) nav(1'b1);
    endtask

    // Full scan from idle or reset; bits in and out LSB first.
    task automatic scan(input bit ir, input int n, input logic [15:0] din,
                        output logic [15:0] dout);
        dout = 16'h0000;
        nav(1'b0);
        nav(1'b1);
        if (ir) nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], dout[i]);
        end
        nav(1'b1);
        nav(1'b0);
    endtask
endmodule

`default_nettype wire

/* File: verification/tb.sv */
/*
 * Self-checking testbench for the scan block with the controller model on the link.
 * Assumes a 25 MHz system clock and a free 15 ns test clock from the model.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic sys_clk_in;
    logic rst_n_in;
    logic clk_en_in;
    wire logic tck;
    wire logic tms;
    wire logic tdi;
    wire logic tdo;
    wire logic tdo_oe;
    wire logic [7:0] instr;
    wire logic [7:0] dr;
    wire logic byp;
    int n_fail;
    int tests_run;
    logic [15:0] got;

    tap_ir_bypass_scan tap_ir_bypass_scan_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
        .tdo_oe_out(tdo_oe), .instr_out(instr), .dr_par_out(dr), .bypass_sel_out(byp));
    scan_ctrl_model scan_ctrl_model_i (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .tdo_in(tdo), .tdo_oe_in(tdo_oe));

    // Compares and counts one value.
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            n_fail++;
        end
    endtask

    // Prints counts and the verdict, then stops.
    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Waits, bounded, for the system-side outputs to reach the expected values.
    task automatic await(input logic [7:0] ei, input logic [7:0] ed, input logic eb);
        int i;
        for (i = 0; i < 200 && !(instr === ei && dr === ed && byp === eb); i++) begin
            @(negedge sys_clk_in);
        end
        chk({instr, dr}, {ei, ed});
        chk({15'h0000, byp}, {15'h0000, eb});
        if (i >= 200) test_done();
    endtask

    // A general instruction shifts in while the capture pattern shifts out.
    task automatic t_ir_general();
        scan_ctrl_model_i.scan(1'b1, 8, 16'h005A, got);
        chk(got, 16'h0081);
        await(8'h5A, 8'h00, 1'b0);
    endtask

    // The general data register captures its latch and updates it.
    task automatic t_dr_general();
        scan_ctrl_model_i.scan(1'b0, 8, 16'h00C3, got);
        chk(got, 16'h0000);
        await(8'h5A, 8'hC3, 1'b0);
        scan_ctrl_model_i.scan(1'b0, 8, 16'h003C, got);
        chk(got, 16'h00C3);
        await(8'h5A, 8'h3C, 1'b0);
    endtask

    // All ones selects bypass.
    task automatic t_ir_bypass();
        scan_ctrl_model_i.scan(1'b1, 8, 16'h00FF, got);
        chk(got, 16'h0081);
        await(8'hFF, 8'h3C, 1'b1);
    endtask

    // Bypass gives 0 first, then each bit one cycle late; latch untouched.
    task automatic t_bypass_dr();
        scan_ctrl_model_i.scan(1'b0, 3, 16'h0005, got);
        chk(got, 16'h0002);
        scan_ctrl_model_i.scan(1'b0, 16, 16'hA5F0, got);
        chk(got, 16'h4BE0);
        await(8'hFF, 8'h3C, 1'b1);
    endtask

    // A paused bypass scan keeps its stage through pause and exit-2.
    task automatic t_pause();
        logic [2:0] v;
        logic q;
        scan_ctrl_model_i.step(1'b1, 1'b0, q);
        scan_ctrl_model_i.step(1'b0, 1'b0, q);
        scan_ctrl_model_i.step(1'b0, 1'b0, q);
        scan_ctrl_model_i.step(1'b0, 1'b1, v[0]);
        scan_ctrl_model_i.step(1'b1, 1'b0, v[1]);
        scan_ctrl_model_i.step(1'b0, 1'b1, q);
        scan_ctrl_model_i.step(1'b0, 1'b1, q);
        scan_ctrl_model_i.step(1'b1, 1'b1, q);
        scan_ctrl_model_i.step(1'b0, 1'b1, q);
        scan_ctrl_model_i.step(1'b1, 1'b1, v[2]);
        scan_ctrl_model_i.step(1'b1, 1'b0, q);
        scan_ctrl_model_i.step(1'b0, 1'b0, q);
        chk({13'h0000, v}, 16'h0002);
    endtask

    // A reset in mid-run restores the outputs and clears the data latch.
    task automatic t_reset();
        @(negedge sys_clk_in);
        rst_n_in = 1'b0;
        repeat (20) @(negedge sys_clk_in);
        chk({instr, dr}, 16'hFF00);
        chk({15'h0000, byp}, 16'h0001);
        rst_n_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        scan_ctrl_model_i.to_tlr();
        scan_ctrl_model_i.scan(1'b1, 8, 16'h005A, got);
        chk(got, 16'h0081);
        await(8'h5A, 8'h00, 1'b0);
    endtask

    // Reset state restores the bypass instruction.
    task automatic t_tlr();
        scan_ctrl_model_i.scan(1'b1, 8, 16'h005A, got);
        await(8'h5A, 8'h3C, 1'b0);
        scan_ctrl_model_i.to_tlr();
        await(8'hFF, 8'h3C, 1'b1);
    endtask

    // System clock at 25 MHz.
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // Reset, then the scenarios in order.
    initial begin
        rst_n_in = 1'b0;
        clk_en_in = 1'b1;
        n_fail = 0;
        tests_run = 0;
        repeat (20) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        scan_ctrl_model_i.to_tlr();
        t_ir_general();
        t_dr_general();
        t_ir_bypass();
        t_bypass_dr();
        t_pause();
        t_tlr();
        t_reset();
        test_done();
    end
endmodule

bind tap_ir_bypass_scan tap_scan_checker tap_scan_checker_i (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .tck_in(tck_in), .tms_in(tms_in),
    .tdi_in(tdi_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .instr_out(instr_out),
    .dr_par_out(dr_par_out), .bypass_sel_out(bypass_sel_out));

`default_nettype wire
